// File: core/pab_device.sv
`timescale 1ns/100ps
module pab_device (
   pab_link_if.device                link,                 // Pins to bridge and initiators
   input  wire logic                 arbiter_scheme,       // 1 rotating, 0 fixed
   input  wire logic                 guaranteed_access_mode, // Gat mode select
   input  wire logic                 isa_bus_request,      // Isa master or dma wants bus
   output logic                      isa_bus_grant,        // Isa bus granted
   input  wire logic                 own_bus_need,         // Device needs pci bus
   input  wire logic                 resume_event,         // Retry condition cleared, pulse
   input  wire logic                 pci_bus_idle,         // Pci bus idle
   output logic                      arbiter_enabled,      // Strap result
   output logic                      bridge_granted        // External arbiter grant seen
);
   import pab_pkg::*;

   typedef enum logic [1:0] {PAB_HS_IDLE, PAB_HS_WAIT, PAB_HS_GRANT} pab_hs_type;

   typedef struct packed {
      logic [1:0]              req_s1;        // Synchroniser stage 1: ack, bridge grant
      logic [1:0]              req_s2;        // Stage 2
      logic [PAB_NUM_INIT-1:0] reqv_s1;       // Requests, stage 1
      logic [PAB_NUM_INIT-1:0] reqv_s2;       // Requests, stage 2
      logic                    enabled;       // Strap value
      logic                    driven;        // Outputs driven after reset
      logic [2:0]              park_cnt;      // Park delay counter
      logic                    park_ok;       // Park delay done
      logic [PAB_NUM_INIT-1:0] grant;         // One-hot grant
      logic [2:0]              last;          // Last granted, for rotation
      pab_hs_type              hs;            // Flush handshake state
      logic [1:0]              pair;          // {flush_n, claim_n}
      logic                    resume;        // Resume pulse registered, delayed one clock
   } pab_dev_type;

   pab_dev_type cur;
   pab_dev_type next_cur;
   logic        ack;
   logic [PAB_NUM_INIT-1:0] reqs;
   logic [PAB_NUM_INIT-1:0] pick;
   logic [2:0]  idx;

   assign ack  = ~cur.req_s2[1];
   // Requests honoured only with arbiter enabled
   assign reqs = cur.enabled ? ~cur.reqv_s2 : '0;

   // Choose one requester: fixed from index 0, or rotate after last winner
   always_comb begin
      pick = '0;
      idx  = 3'h0;
      for (int k = 0; k < PAB_NUM_INIT; k++) begin
         if (arbiter_scheme == PAB_SCHEME_ROTATE) begin
            idx = 3'((int'(cur.last) + 1 + k) % PAB_NUM_INIT);
         end else begin
            idx = 3'(k);
         end
         if (pick == '0 && reqs[idx]) begin
            pick[idx] = 1'b1;
         end
      end
   end

   // Next-state logic
   always_comb begin
      next_cur = cur;
      next_cur.req_s1  = {link.memory_handshake_ack_n, link.initiator0_request_n};
      next_cur.req_s2  = cur.req_s1;
      next_cur.reqv_s1 = {link.initiator3_request_n, link.initiator2_request_n,
                          link.initiator1_request_n, link.initiator0_request_n,
                          link.cpu_bus_request_n};
      next_cur.reqv_s2 = cur.reqv_s1;
      next_cur.driven   = 1'b1;
      next_cur.resume   = resume_event;
      // Park delay after release
      if (cur.park_cnt != 3'(PAB_PARK_DELAY)) begin
         next_cur.park_cnt = cur.park_cnt + 3'h1;
      end else begin
         next_cur.park_ok = 1'b1;
      end
      // Hold grant while owner keeps requesting, else re-arbitrate
      if ((cur.grant & reqs) == '0 || !pci_bus_idle) begin
         if ((cur.grant & reqs) == '0) begin
            next_cur.grant = pick;
            for (int k = 0; k < PAB_NUM_INIT; k++) begin
               if (pick[k]) begin
                  next_cur.last = 3'(k);
               end
            end
         end
      end
      // Flush / memory request handshake ahead of isa grant
      case (cur.hs)
         PAB_HS_IDLE: begin
            next_cur.pair = PAB_PAIR_IDLE;
            if (isa_bus_request) begin
               next_cur.hs   = PAB_HS_WAIT;
               next_cur.pair = guaranteed_access_mode ? PAB_PAIR_GAT : PAB_PAIR_FLUSH;
            end
         end
         PAB_HS_WAIT: begin
            if (!isa_bus_request) begin
               next_cur.hs   = PAB_HS_IDLE;
               next_cur.pair = PAB_PAIR_IDLE;
            end else if (ack) begin
               next_cur.hs = PAB_HS_GRANT;
            end
         end
         PAB_HS_GRANT: begin
            if (!isa_bus_request) begin
               next_cur.hs   = PAB_HS_IDLE;
               next_cur.pair = PAB_PAIR_IDLE;
            end
         end
         default: begin
            next_cur.hs   = PAB_HS_IDLE;
            next_cur.pair = PAB_PAIR_IDLE;
         end
      endcase
      // Reset: the strap pin keeps running through its synchroniser, so the
      // last value seen before release fixes the mode until the next reset
      if (link.rst) begin
         next_cur          = '0;
         next_cur.hs       = PAB_HS_IDLE;
         next_cur.pair     = PAB_PAIR_IDLE;
         next_cur.req_s1   = 2'h3;
         next_cur.req_s2   = 2'h3;
         next_cur.reqv_s1  = {{(PAB_NUM_INIT-1){1'b1}}, link.cpu_bus_request_n};
         next_cur.reqv_s2  = {{(PAB_NUM_INIT-1){1'b1}}, cur.reqv_s1[0]};
         next_cur.enabled  = cur.reqv_s2[0];
         next_cur.park_cnt = PAB_PARK_CNT_RST;
         next_cur.last     = PAB_LAST_RST;
      end
   end

   // State register
   always_ff @(posedge link.sys_clk) begin
      cur <= next_cur;
   end

   // Shared pins: arbiter grants or bridge request/resume
   always_comb begin
      link.cpu_bus_grant_oe_n    = ~cur.driven;
      link.initiator0_grant_oe_n = ~cur.driven;
      link.initiator1_grant_oe_n = ~cur.driven;
      if (cur.enabled) begin
         link.cpu_bus_grant_n    = ~cur.grant[PAB_IDX_CPU];
         link.initiator0_grant_n = ~cur.grant[PAB_IDX_INIT0];
         link.initiator1_grant_n = ~cur.grant[PAB_IDX_INIT1];
      end else begin
         link.cpu_bus_grant_n    = 1'b1;
         link.initiator0_grant_n = ~own_bus_need;
         link.initiator1_grant_n = ~cur.resume;
      end
      link.initiator2_grant_n = ~(cur.enabled & cur.grant[PAB_IDX_INIT2]);
      link.initiator3_grant_n = ~(cur.enabled & cur.grant[PAB_IDX_INIT3]);
   end

   // Handshake pins float in reset, idle right after
   assign link.buffer_flush_request_oe_n = link.rst;
   assign link.main_memory_claim_oe_n    = link.rst;
   assign link.buffer_flush_request_n    = cur.pair[1];
   assign link.main_memory_claim_n       = cur.pair[0];
   // Park byte enables and parity while the arbiter is enabled and nobody holds the bus
   assign link.park_drive_oe_n = ~(cur.enabled & cur.park_ok & ~link.rst
                                   & (cur.grant == '0) & pci_bus_idle);
   assign isa_bus_grant   = (cur.hs == PAB_HS_GRANT);
   assign arbiter_enabled = cur.enabled;
   assign bridge_granted  = ~cur.enabled & ~cur.req_s2[0];
endmodule : pab_device

// File: core/pab_pkg.sv
package pab_pkg;
   // Flush/memory request pair encodings {flush_n, claim_n}
   localparam logic [1:0] PAB_PAIR_IDLE    = 2'h3;
   localparam logic [1:0] PAB_PAIR_FLUSH   = 2'h1;
   localparam logic [1:0] PAB_PAIR_RESVD   = 2'h2;
   localparam logic [1:0] PAB_PAIR_GAT     = 2'h0;
   // Delay from reset release to parking the bus, in PCI clocks (2 to 5)
   localparam int         PAB_PARK_DELAY   = 3;
   localparam logic [2:0] PAB_PARK_CNT_RST = 3'h0;
   // Number of initiators served by the internal arbiter (cpu + 0..3)
   localparam int         PAB_NUM_INIT     = 5;
   localparam logic [2:0] PAB_LAST_RST     = 3'h0;
   // Index of each requester in the request vector
   localparam int         PAB_IDX_CPU      = 0;
   localparam int         PAB_IDX_INIT0    = 1;
   localparam int         PAB_IDX_INIT1    = 2;
   localparam int         PAB_IDX_INIT2    = 3;
   localparam int         PAB_IDX_INIT3    = 4;
   // Arbitration schemes
   typedef enum logic {PAB_SCHEME_FIXED, PAB_SCHEME_ROTATE} pab_scheme_type;
endpackage : pab_pkg

// File: core/pab_link_if.sv
`timescale 1ns/100ps
// Pins between the arbiter device and the host bridge / initiators.
// Open pins carry input, output and output enable (enable low = driving).
interface pab_link_if (
   input wire logic sys_clk,                    // PCI clock
   input wire logic rst                         // Bus reset, active high
);
   logic cpu_bus_request_n;                     // Strap at reset, then cpu request
   logic initiator0_request_n;                  // Request 0 or bridge grant in
   logic initiator1_request_n;                  // Request 1
   logic initiator2_request_n;                  // Request 2
   logic initiator3_request_n;                  // Request 3
   logic cpu_bus_grant_n;                       // Cpu grant, output value
   logic cpu_bus_grant_oe_n;                    // Cpu grant enable
   logic initiator0_grant_n;                    // Grant 0 or bridge request out
   logic initiator0_grant_oe_n;                 // Enable
   logic initiator1_grant_n;                    // Grant 1 or resume
   logic initiator1_grant_oe_n;                 // Enable
   logic initiator2_grant_n;                    // Grant 2
   logic initiator3_grant_n;                    // Grant 3
   logic buffer_flush_request_n;                // Flush request
   logic buffer_flush_request_oe_n;             // Enable
   logic main_memory_claim_n;                   // Memory request
   logic main_memory_claim_oe_n;                // Enable
   logic memory_handshake_ack_n;                // Memory acknowledge
   logic park_drive_oe_n;                       // Byte enables and parity driven low

   modport device (
      input  sys_clk, rst, cpu_bus_request_n, initiator0_request_n,
             initiator1_request_n, initiator2_request_n, initiator3_request_n,
             memory_handshake_ack_n,
      output cpu_bus_grant_n, cpu_bus_grant_oe_n, initiator0_grant_n,
             initiator0_grant_oe_n, initiator1_grant_n, initiator1_grant_oe_n,
             initiator2_grant_n, initiator3_grant_n, buffer_flush_request_n,
             buffer_flush_request_oe_n, main_memory_claim_n, main_memory_claim_oe_n,
             park_drive_oe_n
   );
   modport bridge (
      input  sys_clk, rst, cpu_bus_grant_n, cpu_bus_grant_oe_n, initiator0_grant_n,
             initiator0_grant_oe_n, initiator1_grant_n, initiator1_grant_oe_n,
             initiator2_grant_n, initiator3_grant_n, buffer_flush_request_n,
             buffer_flush_request_oe_n, main_memory_claim_n, main_memory_claim_oe_n,
             park_drive_oe_n,
      output cpu_bus_request_n, initiator0_request_n, initiator1_request_n,
             initiator2_request_n, initiator3_request_n, memory_handshake_ack_n
   );
endinterface : pab_link_if

// File: core/pab_bridge.sv
`timescale 1ns/100ps
// Host bridge end: strap, requests, and flush acknowledge.
module pab_bridge (
   pab_link_if.bridge                link,                 // Pins to device
   input  wire logic                 want_arbiter,         // Strap value to present
   input  wire logic [4:0]           user_request,         // cpu, init0..3 requests
   input  wire logic                 flush_done,           // Buffers flushed, memory ready
   output logic [4:0]                user_grant,           // Grants seen, active high
   output logic                      flush_pending,        // Flush or gat asked
   output logic                      gat_pending           // Gat asked
);
   import pab_pkg::*;

   typedef struct packed {
      logic [1:0] s1;                            // Stage 1: flush_n, claim_n
      logic [1:0] s2;                            // Stage 2
      logic       ack;                           // Acknowledge driven
   } pab_br_type;

   pab_br_type cur;
   pab_br_type next_cur;

   // Acknowledge while request stands and work done
   always_comb begin
      next_cur     = cur;
      next_cur.s1  = {link.buffer_flush_request_n, link.main_memory_claim_n};
      next_cur.s2  = cur.s1;
      next_cur.ack = (cur.s2 != PAB_PAIR_IDLE) & flush_done;
      if (rst_active()) begin
         next_cur = '0;
         next_cur.s1 = PAB_PAIR_IDLE;
         next_cur.s2 = PAB_PAIR_IDLE;
      end
   end

   function automatic logic rst_active();
      return link.rst;
   endfunction : rst_active

   always_ff @(posedge link.sys_clk) begin
      cur <= next_cur;
   end

   // Strap held on cpu request during reset
   assign link.cpu_bus_request_n    = link.rst ? want_arbiter : ~user_request[0];
   assign link.initiator0_request_n = ~user_request[1];
   assign link.initiator1_request_n = ~user_request[2];
   assign link.initiator2_request_n = ~user_request[3];
   assign link.initiator3_request_n = ~user_request[4];
   assign link.memory_handshake_ack_n = ~cur.ack;
   assign user_grant = {~link.initiator3_grant_n, ~link.initiator2_grant_n,
                        ~link.initiator1_grant_n, ~link.initiator0_grant_n,
                        ~link.cpu_bus_grant_n};
   assign flush_pending = (cur.s2 == PAB_PAIR_FLUSH) | (cur.s2 == PAB_PAIR_GAT);
   assign gat_pending   = (cur.s2 == PAB_PAIR_GAT);
endmodule : pab_bridge

// File: test/pab_assertions.sv
`timescale 1ns/100ps
// Watches the link pins between the device end and the bridge end
module pab_assertions (
   input wire logic sys_clk,                   // Clock
   input wire logic rst,                       // Reset
   input wire logic cpu_bus_request_n,         // Strap, then cpu request
   input wire logic cpu_bus_grant_n,           // Cpu grant
   input wire logic cpu_bus_grant_oe_n,        // Enable
   input wire logic initiator0_grant_n,        // Grant 0
   input wire logic initiator0_grant_oe_n,     // Enable
   input wire logic initiator1_grant_n,        // Grant 1
   input wire logic initiator1_grant_oe_n,     // Enable
   input wire logic initiator2_grant_n,        // Grant 2
   input wire logic initiator3_grant_n,        // Grant 3
   input wire logic buffer_flush_request_n,    // Flush request
   input wire logic buffer_flush_request_oe_n, // Enable
   input wire logic main_memory_claim_n,       // Memory request
   input wire logic main_memory_claim_oe_n,    // Enable
   input wire logic park_drive_oe_n            // Park drive
);
   typedef struct packed {
      logic strap_on;                          // Strap captured
   } pab_chk_state_type;
   pab_chk_state_type state;
   pab_chk_state_type next_state;
   logic              on_now;                  // Arbiter enabled as seen now

   // Follow the strap pin while reset is applied; the last value holds after
   always_comb begin
      next_state = state;
      if (rst) begin
         next_state.strap_on = cpu_bus_request_n;
      end
   end

   // State register
   always_ff @(posedge sys_clk) begin
      state <= next_state;
   end

   // Strap value in force since reset release
   assign on_now = state.strap_on;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   AST_GNT_RST: assert property ($fell(rst) |-> $past(initiator2_grant_n)
      && $past(initiator3_grant_n) && $past(cpu_bus_grant_oe_n)) else $error("grant reset");
   AST_GNT_DRIVEN: assert property (!$past(rst) |-> !cpu_bus_grant_oe_n
      && !initiator0_grant_oe_n && !initiator1_grant_oe_n) else $error("grant float");
   AST_PAIR_FLOAT: assert property ($fell(rst) |-> $past(buffer_flush_request_oe_n)
      && $past(main_memory_claim_oe_n) && !buffer_flush_request_oe_n
      && buffer_flush_request_n && main_memory_claim_n) else $error("pair reset");
   AST_PAIR_CODE: assert property (main_memory_claim_n || !buffer_flush_request_n)
      else $error("pair reserved");
   AST_CLAIM_FLUSH: assert property ($fell(main_memory_claim_n)
      |-> $fell(buffer_flush_request_n)) else $error("claim alone");
   AST_ONE_GRANT: assert property (on_now |-> $onehot0(~{cpu_bus_grant_n,
      initiator0_grant_n, initiator1_grant_n, initiator2_grant_n, initiator3_grant_n}))
      else $error("two grants");
   AST_OFF_QUIET: assert property (!on_now |-> cpu_bus_grant_n && initiator2_grant_n
      && initiator3_grant_n) else $error("grant while off");
   AST_PARK_START: assert property ($fell(rst) && on_now
      |-> ##[1:6] !park_drive_oe_n) else $error("no park");
   AST_NO_PARK_OFF: assert property (!on_now |-> park_drive_oe_n)
      else $error("park while off");
endmodule : pab_assertions

// File: test/pci_arbiter_flush_handshake_tb.sv
`timescale 1ns/100ps
module pci_arbiter_flush_handshake_tb;
   import pab_pkg::*;
   logic       sys_clk, rst, arbiter_scheme, guaranteed_access_mode, isa_bus_request;
   logic       isa_bus_grant, own_bus_need, resume_event, pci_bus_idle, arbiter_enabled;
   logic       bridge_granted, want_arbiter, flush_done, flush_pending, gat_pending;
   logic [4:0] user_request, user_grant;
   logic [1:0] pair;
   int         err_count, compares, cycles;

   pab_link_if pab_link_if_inst (.sys_clk(sys_clk), .rst(rst));
   pab_device pab_device_inst (.link(pab_link_if_inst), .arbiter_scheme(arbiter_scheme),
      .guaranteed_access_mode(guaranteed_access_mode), .isa_bus_request(isa_bus_request),
      .isa_bus_grant(isa_bus_grant), .own_bus_need(own_bus_need),
      .resume_event(resume_event), .pci_bus_idle(pci_bus_idle),
      .arbiter_enabled(arbiter_enabled), .bridge_granted(bridge_granted));
   pab_bridge pab_bridge_inst (.link(pab_link_if_inst), .want_arbiter(want_arbiter),
      .user_request(user_request), .flush_done(flush_done), .user_grant(user_grant),
      .flush_pending(flush_pending), .gat_pending(gat_pending));
   pab_assertions pab_assertions_inst (.sys_clk(sys_clk), .rst(rst),
      .cpu_bus_request_n(pab_link_if_inst.cpu_bus_request_n),
      .cpu_bus_grant_n(pab_link_if_inst.cpu_bus_grant_n),
      .cpu_bus_grant_oe_n(pab_link_if_inst.cpu_bus_grant_oe_n),
      .initiator0_grant_n(pab_link_if_inst.initiator0_grant_n),
      .initiator0_grant_oe_n(pab_link_if_inst.initiator0_grant_oe_n),
      .initiator1_grant_n(pab_link_if_inst.initiator1_grant_n),
      .initiator1_grant_oe_n(pab_link_if_inst.initiator1_grant_oe_n),
      .initiator2_grant_n(pab_link_if_inst.initiator2_grant_n),
      .initiator3_grant_n(pab_link_if_inst.initiator3_grant_n),
      .buffer_flush_request_n(pab_link_if_inst.buffer_flush_request_n),
      .buffer_flush_request_oe_n(pab_link_if_inst.buffer_flush_request_oe_n),
      .main_memory_claim_n(pab_link_if_inst.main_memory_claim_n),
      .main_memory_claim_oe_n(pab_link_if_inst.main_memory_claim_oe_n),
      .park_drive_oe_n(pab_link_if_inst.park_drive_oe_n));

   // Flush and memory request pair as one value
   assign pair = {pab_link_if_inst.buffer_flush_request_n, pab_link_if_inst.main_memory_claim_n};

   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // Hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         finish_test();
      end
   end

   task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic finish_test;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   // Reset with a chosen strap, then confirm the captured mode
   task automatic do_reset(input logic on);
      rst          = 1'b1;
      want_arbiter = on;
      user_request = 5'h00;
      repeat (16) @(negedge sys_clk);
      rst = 1'b0;
      repeat (10) @(negedge sys_clk);
      check("arbiter_enabled", {4'h0, arbiter_enabled}, {4'h0, on});
   endtask : do_reset

   // Present requests and wait a bounded time for the expected grant set
   task automatic expect_grant(input logic [4:0] req, input logic [4:0] exp);
      int n;
      user_request = req;
      n = 0;
      while (user_grant !== exp && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      check("user_grant", user_grant, exp);
   endtask : expect_grant

   // Main sequence
   initial begin
      {rst, want_arbiter, pci_bus_idle} = 3'h7;
      {arbiter_scheme, guaranteed_access_mode, isa_bus_request, flush_done} = 4'h0;
      {own_bus_need, resume_event, user_request} = 7'h00;
      {err_count, compares, cycles} = '0;
      do_reset(1'b1);
      check("park", {4'h0, pab_link_if_inst.park_drive_oe_n}, 5'h00);
      for (int k = 0; k < 5; k++) begin
         expect_grant(5'h01 << k, 5'h01 << k);
         check("park", {4'h0, pab_link_if_inst.park_drive_oe_n}, 5'h01);
         expect_grant(5'h00, 5'h00);
      end
      expect_grant(5'h1f, 5'h01);
      expect_grant(5'h00, 5'h00);
      $display("test fixed priority done");
      arbiter_scheme = 1'b1;
      expect_grant(5'h04, 5'h04);
      expect_grant(5'h00, 5'h00);
      expect_grant(5'h0a, 5'h08);
      expect_grant(5'h00, 5'h00);
      $display("test rotating done");
      // Flush alone, then guaranteed access, each acknowledged late
      for (int g = 0; g < 2; g++) begin
         guaranteed_access_mode = g[0];
         isa_bus_request = 1'b1;
         repeat (8) @(negedge sys_clk);
         check("pair", {3'h0, pair}, {3'h0, g[0] ? PAB_PAIR_GAT : PAB_PAIR_FLUSH});
         check("pending", {3'h0, flush_pending, gat_pending}, {4'h1, g[0]});
         check("isa_bus_grant", {4'h0, isa_bus_grant}, 5'h00);
         flush_done = 1'b1;
         repeat (8) @(negedge sys_clk);
         check("isa_bus_grant", {4'h0, isa_bus_grant}, 5'h01);
         {isa_bus_request, flush_done} = 2'h0;
         @(negedge sys_clk);
         check("pair", {3'h0, pair}, {3'h0, PAB_PAIR_IDLE});
         // Let the acknowledge die away before the next request
         repeat (6) @(negedge sys_clk);
         check("isa_bus_grant", {4'h0, isa_bus_grant}, 5'h00);
         $display("test handshake %0d done", g);
      end
      // External arbiter mode: pins take their alternate meanings
      do_reset(1'b0);
      user_request = 5'h1f;
      own_bus_need = 1'b1;
      repeat (6) @(negedge sys_clk);
      check("grants", {pab_link_if_inst.cpu_bus_grant_n, pab_link_if_inst.initiator2_grant_n,
         pab_link_if_inst.initiator3_grant_n, 2'h0}, 5'h1c);
      check("bridge_request_out", {4'h0, pab_link_if_inst.initiator0_grant_n}, 5'h00);
      check("bridge_granted", {4'h0, bridge_granted}, 5'h01);
      resume_event = 1'b1;
      @(negedge sys_clk);
      resume_event = 1'b0;
      check("resume", {4'h0, pab_link_if_inst.initiator1_grant_n}, 5'h00);
      @(negedge sys_clk);
      check("resume", {4'h0, pab_link_if_inst.initiator1_grant_n}, 5'h01);
      $display("test external arbiter done");
      finish_test();
   end
endmodule : pci_arbiter_flush_handshake_tb
